/* File: hdl/ats_pkg.sv */
// Purpose: Shared constants and types for the acquisition trigger sequencer
// Assumes: Host writes arrive synchronous to clk
// Notes: Mode byte fields, write window decode and sequencer states
`default_nettype none
package ats_pkg;
  // Host write window
  localparam logic [15:0] ATS_WIN_BASE = 16'h6080;
  localparam logic [15:0] ATS_MODE_ADDR = 16'h6082;
  localparam int ATS_WIN_LSB = 3;
  // Commands by low address bits
  localparam logic [2:0] ATS_CMD_RESTART = 3'h0;
  localparam logic [2:0] ATS_CMD_MANUAL = 3'h1;
  localparam logic [2:0] ATS_CMD_MODE = 3'h2;
  localparam logic [2:0] ATS_CMD_LAT_LO = 3'h3;
  localparam logic [2:0] ATS_CMD_LAT_HI = 3'h4;
  localparam logic [2:0] ATS_CMD_LOAD = 3'h5;
  localparam logic [2:0] ATS_CMD_CLEAR = 3'h7;
  // Mode byte field positions
  localparam int ATS_JIT_LSB = 6;
  localparam int ATS_REC_LSB = 4;
  localparam int ATS_ONE_BIT = 3;
  localparam int ATS_DSRC_BIT = 2;
  localparam int ATS_MAIN_LSB = 0;
  // Reset values
  localparam logic [7:0] ATS_MODE_RST = 8'h00;
  localparam logic [7:0] ATS_LAT_RST = 8'h00;
  localparam int ATS_DLY_W = 16;
  localparam logic [ATS_DLY_W-1:0] ATS_CNT_RST = 16'h0000;
  // Field encodings
  localparam logic [1:0] ATS_JIT_A = 2'h0;
  localparam logic [1:0] ATS_JIT_END_EVT = 2'h2;
  localparam logic [1:0] ATS_REC_A = 2'h0;
  localparam logic [1:0] ATS_REC_DLY_TIME = 2'h1;
  localparam logic [1:0] ATS_REC_DLY_EVT = 2'h2;
  localparam logic [1:0] ATS_REC_B_AFTER = 2'h3;
  localparam logic [1:0] ATS_MAIN_INST = 2'h0;
  localparam logic [1:0] ATS_MAIN_VIDEO = 2'h1;
  localparam logic [1:0] ATS_MAIN_WORD = 2'h2;
  // Sequencer states
  typedef enum logic [2:0] {
    ATS_IDLE,
    ATS_WAIT_PRE,
    ATS_ARMED,
    ATS_DELAY,
    ATS_WAIT_B,
    ATS_DONE
  } ats_state_t;
endpackage : ats_pkg
`default_nettype wire

/* File: hdl/ats_sync.sv */
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Inputs asynchronous to clk
// Notes: Output changes only when stages two and three agree
`default_nettype none
module ats_sync #(
  parameter int W = 1
) (
  input wire logic clk, // System clock
  input wire logic rst, // Async reset, high
  input wire logic [W-1:0] din, // Raw pins
  output logic [W-1:0] dout // Filtered levels
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_dout;

  // Take stage three where stages agree, else hold
  always_comb begin
    next_dout = (s3 & ~(s2 ^ s3)) | (dout & (s2 ^ s3));
  end

  // Synchroniser chain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      dout <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= next_dout;
    end
  end
endmodule : ats_sync
`default_nettype wire

/* File: hdl/ats_trigger_sequencer.sv */
// Purpose: Final trigger source selection, delay counting and trigger outputs
// Assumes: Host write port synchronous to clk; trigger pins asynchronous
// Notes: Differential gates are true when the positive leg is high, negative low
// What this block does
// - Host-written 8-bit mode byte at fixed address
// - Mode byte: jitter, record, single, delay, main
// - Jitter source: A, B, end events, B
// - Record source: A, delay time, delay events, B
// - Main source: main, video, word, main and delay gates
// - Ignore triggers until pretrigger done rises
// - Armed: A event on main gate starts delay
// - Qualifying event fires jitter trigger and ramps
// - Delay clock decrements count down to zero
// - Delay-by-B mode: B events decrement count
// - Record trigger when delay count hits zero
// - B-after mode: wait B event after delay
// - No jitter or record triggers while pretrigger done low
// - External clock mode: external clock times delay
// - Active-low buffered A and record triggers
// - Eight-address write window command decode
// - Record trigger resynced to B-register clock
`default_nettype none
module ats_trigger_sequencer
  import ats_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst, // Async reset, high
  input wire logic host_wr, // Host write strobe
  input wire logic [15:0] host_addr, // Host write address
  input wire logic [7:0] mode_byte_bus, // Host write data
  input wire logic pretrigger_done, // Pretrigger holdoff ended
  input wire logic main_trigger_gate_p, // Main gate, true leg
  input wire logic main_trigger_gate_n, // Main gate, inverted leg
  input wire logic delay_trigger_gate_p, // Delay gate, true leg
  input wire logic delay_trigger_gate_n, // Delay gate, inverted leg
  input wire logic video_trigger, // Video option trigger
  input wire logic word_trigger, // Word option trigger
  input wire logic delay_count_clock, // Delay clock pin
  input wire logic b_register_clock, // B-register clock pin
  input wire logic ext_clock_mode, // External clock selected
  input wire logic external_sample_clock_p, // External clock, true leg
  input wire logic external_sample_clock_n, // External clock, inverted leg
  output logic jitter_trigger, // Jitter trigger pulse
  output logic ramp_p, // Ramp start, true
  output logic ramp_n, // Ramp start, inverted
  output logic record_trigger, // Record trigger pulse
  output logic synchronous_trigger, // Record trigger on B clock
  output logic a_trigger_out_n, // Buffered A trigger, low
  output logic record_trigger_out_n // Buffered record trigger, low
);
  localparam int NPIN = 12;
  logic [NPIN-1:0] pins;
  logic pre;
  logic mtg_p, mtg_n, dtg_p, dtg_n, vid, wrd, dclk, bclk, ext, xck_p, xck_n;
  logic [7:0] mode, next_mode, lat_lo, next_lat_lo, lat_hi, next_lat_hi;
  logic [1:0] jit_src, rec_src, main_src;
  logic one_evt, dsrc;
  logic wr_win, cmd_restart, cmd_manual, cmd_load, cmd_clear;
  logic a_lvl, b_lvl, a_lvl_q, b_lvl_q, dclk_q, bclk_q, xck_q;
  logic a_evt, b_evt, a_hit, b_hit, tick, bclk_rise, events_mode;
  ats_state_t state, next_state;
  logic [ATS_DLY_W-1:0] cnt, next_cnt;
  logic a_seen, next_a_seen, jit_done, next_jit_done;
  logic next_jit, next_rec, next_ramp, syn_pend, next_syn_pend, next_syn;

  // Bring all pins into the clock domain
  ats_sync #(.W(NPIN)) u_sync (
    .clk(clk),
    .rst(rst),
    .din({pretrigger_done, main_trigger_gate_p, main_trigger_gate_n,
          delay_trigger_gate_p, delay_trigger_gate_n, video_trigger, word_trigger,
          delay_count_clock, b_register_clock, ext_clock_mode,
          external_sample_clock_p, external_sample_clock_n}),
    .dout(pins)
  );
  assign {pre, mtg_p, mtg_n, dtg_p, dtg_n, vid, wrd, dclk, bclk, ext, xck_p, xck_n} = pins;

  // Mode byte fields
  assign jit_src = mode[ATS_JIT_LSB +: 2];
  assign rec_src = mode[ATS_REC_LSB +: 2];
  assign one_evt = mode[ATS_ONE_BIT];
  assign dsrc = mode[ATS_DSRC_BIT];
  assign main_src = mode[ATS_MAIN_LSB +: 2];

  // Eight-address write window decode
  assign wr_win = host_wr && (host_addr[15:ATS_WIN_LSB] == ATS_WIN_BASE[15:ATS_WIN_LSB]);
  assign cmd_restart = wr_win && (host_addr[2:0] == ATS_CMD_RESTART);
  assign cmd_manual = wr_win && (host_addr[2:0] == ATS_CMD_MANUAL);
  assign cmd_load = wr_win && (host_addr[2:0] == ATS_CMD_LOAD);
  assign cmd_clear = wr_win && (host_addr[2:0] == ATS_CMD_CLEAR);

  // Host-written registers
  always_comb begin
    next_mode = mode;
    next_lat_lo = lat_lo;
    next_lat_hi = lat_hi;
    if (cmd_clear) begin
      next_mode = ATS_MODE_RST;
      next_lat_lo = ATS_LAT_RST;
      next_lat_hi = ATS_LAT_RST;
    end else if (wr_win && host_addr[2:0] == ATS_CMD_MODE) begin
      next_mode = mode_byte_bus;
    end else if (wr_win && host_addr[2:0] == ATS_CMD_LAT_LO) begin
      next_lat_lo = mode_byte_bus;
    end else if (wr_win && host_addr[2:0] == ATS_CMD_LAT_HI) begin
      next_lat_hi = mode_byte_bus;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode <= ATS_MODE_RST;
      lat_lo <= ATS_LAT_RST;
      lat_hi <= ATS_LAT_RST;
    end else begin
      mode <= next_mode;
      lat_lo <= next_lat_lo;
      lat_hi <= next_lat_hi;
    end
  end

  // Source selection
  always_comb begin
    case (main_src)
      ATS_MAIN_INST: a_lvl = mtg_p && !mtg_n;
      ATS_MAIN_VIDEO: a_lvl = vid;
      ATS_MAIN_WORD: a_lvl = wrd;
      default: a_lvl = mtg_p && !mtg_n && dtg_p && !dtg_n;
    endcase
    b_lvl = dsrc ? wrd : (dtg_p && !dtg_n);
  end

  // Edge detection on selected levels
  assign a_evt = a_lvl && !a_lvl_q;
  assign b_evt = b_lvl && !b_lvl_q;
  assign bclk_rise = bclk && !bclk_q;
  assign a_hit = a_evt || cmd_manual;
  assign b_hit = b_evt || cmd_manual;
  assign events_mode = (rec_src == ATS_REC_DLY_EVT) || (jit_src == ATS_JIT_END_EVT);
  // Events modes count B; otherwise delay clock or external clock
  assign tick = events_mode ? b_evt :
                (ext ? (xck_p && !xck_n && !xck_q) : (dclk && !dclk_q));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      a_lvl_q <= 1'b0;
      b_lvl_q <= 1'b0;
      dclk_q <= 1'b0;
      bclk_q <= 1'b0;
      xck_q <= 1'b0;
    end else begin
      a_lvl_q <= a_lvl;
      b_lvl_q <= b_lvl;
      dclk_q <= dclk;
      bclk_q <= bclk;
      xck_q <= xck_p && !xck_n;
    end
  end

  // Trigger sequencer
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_a_seen = a_seen;
    next_jit_done = jit_done;
    next_jit = 1'b0;
    next_rec = 1'b0;
    case (state)
      ATS_WAIT_PRE: begin
        if (pre) next_state = ATS_ARMED;
      end
      ATS_ARMED: begin
        if (!pre) begin
          next_state = ATS_DONE;
        end else if (a_hit) begin
          if (one_evt || a_seen) begin
            if (jit_src == ATS_JIT_A) next_jit = 1'b1;
            if (rec_src == ATS_REC_A) begin
              next_rec = 1'b1;
              next_state = ATS_DONE;
            end else begin
              next_state = ATS_DELAY;
            end
          end else begin
            next_a_seen = 1'b1;
          end
        end
      end
      ATS_DELAY: begin
        if (!pre) begin
          next_state = ATS_DONE;
        end else begin
          if (b_hit && jit_src[0] && !jit_done) next_jit = 1'b1;
          if (cnt == '0) begin
            if (jit_src == ATS_JIT_END_EVT) next_jit = 1'b1;
            if (rec_src == ATS_REC_B_AFTER) begin
              next_state = ATS_WAIT_B;
            end else begin
              next_rec = 1'b1;
              next_state = ATS_DONE;
            end
          end else if (tick) begin
            next_cnt = cnt - 1'b1;
          end
        end
      end
      ATS_WAIT_B: begin
        if (!pre) begin
          next_state = ATS_DONE;
        end else if (b_hit) begin
          next_rec = 1'b1;
          if (jit_src[0] && !jit_done) next_jit = 1'b1;
          next_state = ATS_DONE;
        end
      end
      default: ;
    endcase
    if (next_jit) next_jit_done = 1'b1;
    if (cmd_load) next_cnt = {lat_hi, lat_lo};
    if (cmd_restart) begin
      next_state = ATS_WAIT_PRE;
      next_a_seen = 1'b0;
      next_jit_done = 1'b0;
      next_jit = 1'b0; // Restart drops a same-cycle jitter trigger, not a record trigger
    end
    if (cmd_clear) begin
      next_state = ATS_IDLE;
      next_cnt = ATS_CNT_RST;
    end
    next_ramp = (ramp_p && !cmd_restart) || next_jit;
    // Resync record trigger to B clock; a new record wins over the clear
    next_syn = syn_pend && bclk_rise;
    next_syn_pend = (syn_pend && !bclk_rise) || next_rec;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ATS_IDLE;
      cnt <= ATS_CNT_RST;
      a_seen <= 1'b0;
      jit_done <= 1'b0;
      jitter_trigger <= 1'b0;
      record_trigger <= 1'b0;
      ramp_p <= 1'b0;
      ramp_n <= 1'b1;
      syn_pend <= 1'b0;
      synchronous_trigger <= 1'b0;
      a_trigger_out_n <= 1'b1;
      record_trigger_out_n <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      a_seen <= next_a_seen;
      jit_done <= next_jit_done;
      jitter_trigger <= next_jit;
      record_trigger <= next_rec;
      ramp_p <= next_ramp;
      ramp_n <= !next_ramp;
      syn_pend <= next_syn_pend;
      synchronous_trigger <= next_syn;
      a_trigger_out_n <= !a_lvl_q;
      record_trigger_out_n <= !record_trigger;
    end
  end

  // Checks
  sequence s_armed_hit;
    state == ATS_ARMED && pre && a_hit && one_evt && !cmd_restart && jit_src == ATS_JIT_A;
  endsequence

  property p_mode_load;
    @(posedge clk) disable iff (rst)
    host_wr && host_addr == ATS_MODE_ADDR |=> mode == $past(mode_byte_bus);
  endproperty
  a_mode_load: assert property (p_mode_load) else $error("mode byte not loaded");

  property p_quiet_pre;
    @(posedge clk) disable iff (rst)
    !pre |=> !jitter_trigger && !record_trigger;
  endproperty
  a_quiet_pre: assert property (p_quiet_pre) else $error("trigger while not ready");

  property p_restart;
    @(posedge clk) disable iff (rst)
    cmd_restart && !cmd_clear |=> state == ATS_WAIT_PRE && !ramp_p;
  endproperty
  a_restart: assert property (p_restart) else $error("restart not taken");

  property p_jit_a;
    @(posedge clk) disable iff (rst)
    s_armed_hit |=> jitter_trigger ##1 !jitter_trigger;
  endproperty
  a_jit_a: assert property (p_jit_a) else $error("A trigger missed jitter");

  property p_ramp;
    @(posedge clk) disable iff (rst)
    jitter_trigger |-> ramp_p && !ramp_n;
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp not started");

  property p_dec;
    @(posedge clk) disable iff (rst)
    state == ATS_DELAY && pre && tick && cnt != '0 && !wr_win |=> cnt == $past(cnt) - 1'b1;
  endproperty
  a_dec: assert property (p_dec) else $error("delay count not decremented");

  property p_rec_zero;
    @(posedge clk) disable iff (rst)
    state == ATS_DELAY && pre && cnt == '0 && rec_src == ATS_REC_DLY_TIME && !wr_win
      |=> record_trigger;
  endproperty
  a_rec_zero: assert property (p_rec_zero) else $error("no record at zero");

  property p_wait_b;
    @(posedge clk) disable iff (rst)
    state == ATS_WAIT_B && !b_hit |=> !record_trigger;
  endproperty
  a_wait_b: assert property (p_wait_b) else $error("record without B event");

  property p_out_n;
    @(posedge clk) disable iff (rst)
    record_trigger |=> !record_trigger_out_n;
  endproperty
  a_out_n: assert property (p_out_n) else $error("record copy missing");

  property p_syn;
    @(posedge clk) disable iff (rst)
    synchronous_trigger |-> $past(syn_pend) && $past(bclk_rise);
  endproperty
  a_syn: assert property (p_syn) else $error("sync trigger off B clock");
endmodule : ats_trigger_sequencer
`default_nettype wire

/* File: tb/ats_tb_model.sv */
// Purpose: Time base controller model facing the trigger sequencer
// Assumes: Restart is seen on the shared host write port
// Notes: Delay and B-register clocks are clk dividers; delay clock stands low when off
`default_nettype none
module ats_tb_model #(
  parameter int PRE = 40,
  parameter int POST = 20
) (
  input wire logic clk, // System clock
  input wire logic rst, // Async reset, high
  input wire logic host_wr, // Host write strobe
  input wire logic [15:0] host_addr, // Host write address
  input wire logic synchronous_trigger, // Starts post-trigger count
  input wire logic tick_en, // Lets the delay clock run
  output logic pretrigger_done, // Pretrigger holdoff ended
  output logic delay_count_clock, // Delay clock pin
  output logic b_register_clock // B-register clock pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase;
  logic [7:0] cnt;
  logic [3:0] dcnt;
  logic [3:0] bcnt;
  // Pretrigger and post-trigger sample counting
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= 2'h0;
      cnt <= 8'h00;
      pretrigger_done <= 1'b0;
    end else if (host_wr && host_addr == 16'h6080) begin
      phase <= 2'h1;
      cnt <= 8'(PRE);
      pretrigger_done <= 1'b0;
    end else if (phase == 2'h1 || phase == 2'h3) begin
      cnt <= cnt - 8'h01;
      if (cnt == 8'h00) begin
        phase <= phase + 2'h1;
        pretrigger_done <= (phase == 2'h1);
      end
    end else if (phase == 2'h2 && synchronous_trigger) begin
      phase <= 2'h3;
      cnt <= 8'(POST);
    end
  end
  // Clock dividers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dcnt <= 4'h0;
      bcnt <= 4'h0;
    end else begin
      dcnt <= tick_en ? dcnt + 4'h1 : 4'h0;
      bcnt <= bcnt + 4'h1;
    end
  end
  assign delay_count_clock = dcnt[3];
  assign b_register_clock = bcnt[3];
endmodule : ats_tb_model
`default_nettype wire

/* File: tb/tb_ats_trigger_sequencer.sv */
// Purpose: Self-checking bench for the trigger sequencer
// Assumes: Option triggers and external clock driven by the bench
// Notes: Pulse counters track trigger outputs
`default_nettype none
module tb_ats_trigger_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, host_wr, mg, dg, tick_en, vid, wrd, ext_md;
  logic [3:0] xcnt;
  logic [15:0] host_addr;
  logic [7:0] mode_byte_bus;
  logic [15:0] jc, rc, sc, ticks;
  wire logic pre_done, dclk, bclk, jit, ramp_p, ramp_n, rec, syn, a_n, r_n;
  int error_cnt, comparisons;

  ats_trigger_sequencer i_ats_trigger_sequencer (
    .clk(clk), .rst(rst), .host_wr(host_wr), .host_addr(host_addr),
    .mode_byte_bus(mode_byte_bus), .pretrigger_done(pre_done),
    .main_trigger_gate_p(mg), .main_trigger_gate_n(~mg),
    .delay_trigger_gate_p(dg), .delay_trigger_gate_n(~dg),
    .video_trigger(vid), .word_trigger(wrd), .delay_count_clock(dclk),
    .b_register_clock(bclk), .ext_clock_mode(ext_md),
    .external_sample_clock_p(xcnt[3]), .external_sample_clock_n(~xcnt[3]),
    .jitter_trigger(jit), .ramp_p(ramp_p), .ramp_n(ramp_n), .record_trigger(rec),
    .synchronous_trigger(syn), .a_trigger_out_n(a_n), .record_trigger_out_n(r_n)
  );
  ats_tb_model i_ats_tb_model (
    .clk(clk), .rst(rst), .host_wr(host_wr), .host_addr(host_addr),
    .synchronous_trigger(syn), .tick_en(tick_en), .pretrigger_done(pre_done),
    .delay_count_clock(dclk), .b_register_clock(bclk)
  );

  // Clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Pulse counters
  always @(posedge clk) begin
    if (jit) jc <= jc + 16'h0001;
    if (rec) rc <= rc + 16'h0001;
    if (syn) sc <= sc + 16'h0001;
  end
  always @(posedge dclk) ticks <= ticks + 16'h0001;
  // External sample clock, runs only while external mode is selected
  always @(posedge clk) xcnt <= ext_md ? xcnt + 4'h1 : 4'h0;

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    host_wr <= 1'b1;
    host_addr <= a;
    mode_byte_bus <= d;
    @(posedge clk);
    host_wr <= 1'b0;
  endtask : wr
  task automatic arm(input logic [7:0] m, input logic [15:0] n);
    wr(16'h6083, n[7:0]);
    wr(16'h6084, n[15:8]);
    wr(16'h6085, 8'h00);
    wr(16'h6082, m);
    wr(16'h6080, 8'h00);
  endtask : arm
  task automatic wait_pre();
    int k;
    for (k = 0; k < 200 && pre_done !== 1'b1; k++) @(posedge clk);
    repeat (6) @(posedge clk);
  endtask : wait_pre
  // One trigger gate event of 7 cycles
  task automatic gate(input bit dly);
    @(posedge clk);
    if (dly) dg <= 1'b1;
    else mg <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    if (!dly) chk("a_trigger_out_n", 16'h0, a_n);
    @(posedge clk);
    mg <= 1'b0;
    dg <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : gate
  // One option trigger pulse of 7 cycles, video or word
  task automatic opt(input bit w);
    @(posedge clk);
    if (w) wrd <= 1'b1;
    else vid <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    if (!w) chk("a_trigger_out_n", 16'h0, a_n);
    @(posedge clk);
    vid <= 1'b0;
    wrd <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : opt
  task automatic waitc(ref logic [15:0] c, input logic [15:0] t, input string nm);
    int k;
    for (k = 0; k < 200 && c !== t; k++) begin
      @(posedge clk);
      #1;
    end
    chk(nm, t, c);
  endtask : waitc
  task automatic fin(input string nm);
    repeat (40) @(posedge clk);
    tick_en <= 1'b0;
    ext_md <= 1'b0;
    $display("test %s done", nm);
    @(posedge clk);
    jc = 16'h0000;
    rc = 16'h0000;
    sc = 16'h0000;
  endtask : fin
  task automatic print_verdict();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("watchdog expired");
    print_verdict();
  end

  // Test sequence
  initial begin
    rst = 1'b1;
    host_wr = 1'b0;
    host_addr = 16'h0000;
    mode_byte_bus = 8'h00;
    mg = 1'b0;
    dg = 1'b0;
    tick_en = 1'b0;
    vid = 1'b0;
    wrd = 1'b0;
    ext_md = 1'b0;
    {jc, rc, sc, ticks} = 64'h0;
    error_cnt = 0;
    comparisons = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("ramp_n", 16'h1, ramp_n);
    chk("ramp_p", 16'h0, ramp_p);
    chk("record_trigger_out_n", 16'h1, r_n);
    fin("reset");
    // Delay time then record, count 3
    arm(8'h18, 16'h0003);
    gate(1'b0);
    chk("early jitter", 16'h0, jc);
    wait_pre();
    gate(1'b0);
    chk("jitter count", 16'h1, jc);
    chk("ramp_p", 16'h1, ramp_p);
    chk("ramp_n", 16'h0, ramp_n);
    ticks = 16'h0000;
    tick_en <= 1'b1;
    waitc(rc, 16'h1, "record count");
    chk("delay ticks", 16'h3, ticks);
    chk("record_trigger_out_n", 16'h0, r_n);
    waitc(sc, 16'h1, "sync count");
    repeat (40) @(posedge clk);
    gate(1'b0);
    chk("late jitter", 16'h1, jc);
    fin("delay time");
    // Manual trigger with record on A
    arm(8'h08, 16'h0000);
    wait_pre();
    wr(16'h6081, 8'h00);
    waitc(jc, 16'h1, "manual jitter");
    chk("record with jitter", 16'h1, rc);
    fin("manual");
    // B event after delay
    arm(8'h78, 16'h0001);
    wait_pre();
    tick_en <= 1'b1;
    gate(1'b0);
    repeat (60) @(posedge clk);
    chk("record before B", 16'h0, rc);
    chk("jitter before B", 16'h0, jc);
    gate(1'b1);
    chk("record after B", 16'h1, rc);
    chk("jitter on B", 16'h1, jc);
    fin("b after");
    // Delay by B events, count 2
    arm(8'hA8, 16'h0002);
    wait_pre();
    gate(1'b0);
    tick_en <= 1'b1;
    repeat (60) @(posedge clk);
    chk("record on clock", 16'h0, rc);
    chk("jitter before end", 16'h0, jc);
    gate(1'b1);
    chk("record after 1 B", 16'h0, rc);
    gate(1'b1);
    chk("record after 2 B", 16'h1, rc);
    chk("jitter at end", 16'h1, jc);
    fin("b events");
    // Word as B source, external clock times the delay, count 2
    arm(8'h3C, 16'h0002);
    ext_md <= 1'b1;
    wait_pre();
    gate(1'b0);
    repeat (60) @(posedge clk);
    gate(1'b1);
    chk("record on delay gate", 16'h0, rc);
    opt(1'b1);
    chk("record on word", 16'h1, rc);
    fin("word ext");
    // Video as A source, record on A
    arm(8'h09, 16'h0000);
    wait_pre();
    gate(1'b1);
    chk("jitter on delay gate", 16'h0, jc);
    opt(1'b0);
    chk("jitter on video", 16'h1, jc);
    chk("record on video", 16'h1, rc);
    fin("video");
    // Word as A source, record on A
    arm(8'h0A, 16'h0000);
    wait_pre();
    opt(1'b1);
    chk("jitter on word", 16'h1, jc);
    fin("word main");
    // Clear, ignored writes, multiple events
    arm(8'h08, 16'h0000);
    wr(16'h6087, 8'h00);
    wr(16'h6092, 8'h08);
    wr(16'h6086, 8'h08);
    wr(16'h6080, 8'h00);
    wait_pre();
    gate(1'b0);
    chk("first A event", 16'h0, jc);
    gate(1'b0);
    chk("second A event", 16'h1, jc);
    chk("record on A", 16'h1, rc);
    fin("multi event");
    print_verdict();
  end
endmodule : tb_ats_trigger_sequencer
`default_nettype wire
